// ---- src/mpfc_alu.sv ----
// Eight-bit arithmetic and logic unit of the program-flow core.
`timescale 1ns/10ps
module mpfc_alu (
   input wire logic [3:0] op,
   input wire logic [7:0] a,
   input wire logic [7:0] b,
   input wire logic cIn,
   input wire logic acIn,
   output logic [7:0] res,
   output logic cOut,
   output logic acOut,
   output logic ovOut,
   output logic zOut,
   output logic updC,
   output logic updAcOv
);

   logic [7:0] bx;
   logic ci;
   logic [8:0] sum;
   logic [4:0] lo;
   logic [7:0] adj;

   // ==========================================================
   // Function select; unary forms other than DAA work on operand b.
   always_comb begin
      bx = b;
      ci = 1'b0;
      sum = 9'h000;
      lo = 5'h00;
      adj = 8'h00;
      res = b;
      cOut = cIn;
      acOut = acIn;
      ovOut = 1'b0;
      updC = 1'b0;
      updAcOv = 1'b0;
      case (op)
         mpfc_pkg::ALU_ADD, mpfc_pkg::ALU_ADC, mpfc_pkg::ALU_SUB, mpfc_pkg::ALU_SBC: begin
            // Subtract adds the complement; carry set means no borrow.
            bx = (op == mpfc_pkg::ALU_SUB || op == mpfc_pkg::ALU_SBC) ? ~b : b;
            ci = (op == mpfc_pkg::ALU_SUB) ? 1'b1 : (op == mpfc_pkg::ALU_ADD) ? 1'b0 : cIn;
            sum = {1'b0, a} + {1'b0, bx} + {8'h00, ci};
            lo = {1'b0, a[3:0]} + {1'b0, bx[3:0]} + {4'h0, ci};
            res = sum[7:0];
            cOut = sum[8];
            acOut = lo[4];
            ovOut = (a[7] == bx[7]) && (sum[7] != a[7]);
            updC = 1'b1;
            updAcOv = 1'b1;
         end
         mpfc_pkg::ALU_DAA: begin
            if (a[3:0] > mpfc_pkg::DAA_LIMIT || acIn) begin
               adj[3:0] = mpfc_pkg::DAA_ADJ;
            end
            if (a[7:4] > mpfc_pkg::DAA_LIMIT || cIn) begin
               adj[7:4] = mpfc_pkg::DAA_ADJ;
            end
            sum = {1'b0, a} + {1'b0, adj};
            res = sum[7:0];
            cOut = cIn | sum[8];
            updC = 1'b1;
         end
         mpfc_pkg::ALU_AND: res = a & b;
         mpfc_pkg::ALU_OR: res = a | b;
         mpfc_pkg::ALU_XOR: res = a ^ b;
         mpfc_pkg::ALU_CPL: res = ~b;
         mpfc_pkg::ALU_RR: res = {b[0], b[7:1]};
         mpfc_pkg::ALU_RRC: begin
            res = {cIn, b[7:1]};
            cOut = b[0];
            updC = 1'b1;
         end
         mpfc_pkg::ALU_RL: res = {b[6:0], b[7]};
         mpfc_pkg::ALU_RLC: begin
            res = {b[6:0], cIn};
            cOut = b[7];
            updC = 1'b1;
         end
         mpfc_pkg::ALU_INC: res = b + 8'h01;
         mpfc_pkg::ALU_DEC: res = b - 8'h01;
         default: res = b;
      endcase
      zOut = (res == 8'h00);
   end

endmodule : mpfc_alu

// ---- src/mpfc_core.sv ----
// Program-flow core: four-phase cycle, prefetch pipeline, counter and APB slave.
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/10ps

module mpfc_core (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [mpfc_pkg::PC_W-1:0] progAddr,
   input wire logic [15:0] progData,
   output logic [7:0] dataAddr,
   output logic dataWe,
   output logic [7:0] dataWdata,
   input wire logic [7:0] dataRdata,
   input wire logic intReq,
   output logic intAck
);

   typedef struct packed {
      mpfc_pkg::mpfc_phase_t ph;
      logic [mpfc_pkg::PC_W-1:0] pc;
      logic [mpfc_pkg::PC_W-1:0] progAddr;
      logic [15:0] fetchIr;
      logic fetchValid;
      logic [15:0] exIr;
      logic exValid;
      logic [7:0] acc;
      logic c;
      logic ac;
      logic z;
      logic ov;
      logic [7:0] dataAddr;
      logic dataWe;
      logic [7:0] dataWdata;
      logic run;
      logic intEnable;
      logic intPending;
      logic intSync1;
      logic intSync2;
      logic intPrev;
      logic intAck;
      logic pclPending;
      logic [7:0] pclValue;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } mpfc_state_t;

   mpfc_state_t r_reg;
   mpfc_state_t r_next;

   mpfc_pkg::mpfc_opword_t irOp;
   mpfc_pkg::mpfc_brword_t irBr;
   mpfc_pkg::mpfc_ctrl_t ctrlWr;
   mpfc_pkg::mpfc_ctrl_t ctrlRd;
   mpfc_pkg::mpfc_status_t statRd;
   logic [7:0] memOperand;
   logic [3:0] aluOp;
   logic [7:0] aluB;
   logic [7:0] aluRes;
   logic aluC;
   logic aluAc;
   logic aluOv;
   logic aluZ;
   logic aluUpdC;
   logic aluUpdAcOv;
   logic push;
   logic pop;
   logic [mpfc_pkg::PC_W-1:0] pushData;
   logic [mpfc_pkg::PC_W-1:0] stackTop;
   logic stackFull;

   // ==========================================================
   // Decode views of the executing word.
   assign irOp = r_reg.exIr;
   assign irBr = r_reg.exIr;

   // The low byte of the counter answers at its data address.
   assign memOperand = (r_reg.dataAddr == mpfc_pkg::PCL_DATA_ADDR)
                       ? r_reg.pc[7:0] : dataRdata;

   // Skip-and-count forms reuse the ALU's increment and decrement.
   always_comb begin
      aluOp = irOp.op;
      if (irOp.cls == mpfc_pkg::CL_SKIP) begin
         aluOp = (irOp.op[1:0] == mpfc_pkg::SK_SDZ) ? mpfc_pkg::ALU_DEC : mpfc_pkg::ALU_INC;
      end
   end

   // Literal forms take the address field as an immediate byte.
   assign aluB = (irOp.cls == mpfc_pkg::CL_LIT) ? irOp.addr : memOperand;

   assign ctrlWr = pwdata;
   assign ctrlRd = '{zero: '0, intEnable: r_reg.intEnable, run: r_reg.run};
   assign statRd = '{zero: '0, intPending: r_reg.intPending, ov: r_reg.ov,
                     z: r_reg.z, ac: r_reg.ac, c: r_reg.c, acc: r_reg.acc};

   // ==========================================================
   // Datapath and stack instances.
   mpfc_alu u_alu (
      .op(aluOp),
      .a(r_reg.acc),
      .b(aluB),
      .cIn(r_reg.c),
      .acIn(r_reg.ac),
      .res(aluRes),
      .cOut(aluC),
      .acOut(aluAc),
      .ovOut(aluOv),
      .zOut(aluZ),
      .updC(aluUpdC),
      .updAcOv(aluUpdAcOv)
   );

   // The stack has no register port, so software cannot see it.
   mpfc_stack #(
      .DEPTH(mpfc_pkg::STACK_DEPTH)
   ) u_stack (
      .core_clk(core_clk),
      .reset(reset),
      .push(push),
      .pop(pop),
      .pushData(pushData),
      .top(stackTop),
      .full(stackFull)
   );

   // ==========================================================
   // Next-state logic: sequencer, execute, then the APB slave.
   always_comb begin
      logic [mpfc_pkg::PC_W-1:0] fetchPc;
      logic [mpfc_pkg::PC_W-1:0] retAddr;
      logic memWr;
      logic [7:0] memVal;
      logic flow;
      logic aluDone;
      fetchPc = r_reg.pc;
      retAddr = r_reg.pc;
      memWr = 1'b0;
      memVal = r_reg.acc;
      flow = 1'b0;
      aluDone = 1'b0;
      r_next = r_reg;
      push = 1'b0;
      pop = 1'b0;
      pushData = r_reg.pc;
      r_next.dataWe = 1'b0;
      r_next.intAck = 1'b0;
      r_next.pready = 1'b0;
      r_next.pslverr = 1'b0;

      // Interrupt pin: two flops, then an edge on the second one.
      r_next.intSync1 = intReq;
      r_next.intSync2 = r_reg.intSync1;
      r_next.intPrev = r_reg.intSync2;

      if (r_reg.run) begin
         case (r_reg.ph)
            mpfc_pkg::PH_T1: begin
               // The return point is the word not yet executed.
               retAddr = r_reg.fetchValid ? r_reg.pc - 13'h0001 : r_reg.pc;
               if (r_reg.intEnable && r_reg.intPending && !stackFull) begin
                  push = 1'b1;
                  pushData = retAddr;
                  fetchPc = mpfc_pkg::INT_VECTOR;
                  r_next.intPending = 1'b0;
                  r_next.intEnable = 1'b0;
                  r_next.intAck = 1'b1;
                  r_next.exValid = 1'b0;
               end else begin
                  // Prefetched word moves to execute while the next fetch starts.
                  r_next.exIr = r_reg.fetchIr;
                  r_next.exValid = r_reg.fetchValid;
               end
               r_next.progAddr = fetchPc;
               r_next.pc = fetchPc + 13'h0001;
               r_next.ph = mpfc_pkg::PH_T2;
            end
            mpfc_pkg::PH_T2: begin
               r_next.dataAddr = irOp.addr;
               r_next.ph = mpfc_pkg::PH_T3;
            end
            mpfc_pkg::PH_T3: begin
               r_next.ph = mpfc_pkg::PH_T4;
            end
            mpfc_pkg::PH_T4: begin
               r_next.fetchIr = progData;
               r_next.fetchValid = 1'b1;
               r_next.ph = mpfc_pkg::PH_T1;
               if (r_reg.exValid) begin
                  case (irOp.cls)
                     mpfc_pkg::CL_ALU: begin
                        aluDone = 1'b1;
                        if (irOp.destMem) begin
                           memWr = 1'b1;
                           memVal = aluRes;
                        end else begin
                           r_next.acc = aluRes;
                        end
                     end
                     mpfc_pkg::CL_LIT: begin
                        aluDone = 1'b1;
                        r_next.acc = aluRes;
                     end
                     mpfc_pkg::CL_JUMP: begin
                        r_next.pc = irBr.target;
                        flow = 1'b1;
                     end
                     mpfc_pkg::CL_CALL: begin
                        // Pushed even on a full stack; overflow is the caller's risk.
                        push = 1'b1;
                        pushData = r_reg.pc - 13'h0001;
                        r_next.pc = irBr.target;
                        flow = 1'b1;
                     end
                     mpfc_pkg::CL_SKIP: begin
                        case (irOp.op[1:0])
                           mpfc_pkg::SK_SZ: flow = (memOperand == 8'h00);
                           mpfc_pkg::SK_SNZ: flow = (memOperand != 8'h00);
                           default: begin
                              memWr = 1'b1;
                              memVal = aluRes;
                              flow = aluZ;
                           end
                        endcase
                     end
                     mpfc_pkg::CL_RET: begin
                        pop = 1'b1;
                        r_next.pc = stackTop;
                        flow = 1'b1;
                        if (irOp.op[0]) begin
                           r_next.intEnable = 1'b1;
                        end
                     end
                     mpfc_pkg::CL_MOVAM: begin
                        memWr = 1'b1;
                        memVal = r_reg.acc;
                     end
                     default: begin
                     end
                  endcase
               end
               // Flags follow the ALU for ALU-class and literal results; skip-and-count forms leave them.
               if (aluDone) begin
                  r_next.z = aluZ;
                  if (aluUpdC) begin
                     r_next.c = aluC;
                  end
                  if (aluUpdAcOv) begin
                     r_next.ac = aluAc;
                     r_next.ov = aluOv;
                  end
               end
               // A store to the low byte is an in-page jump.
               if (memWr) begin
                  if (r_reg.dataAddr == mpfc_pkg::PCL_DATA_ADDR) begin
                     r_next.pc = {r_reg.pc[mpfc_pkg::PC_W-1:8], memVal};
                     flow = 1'b1;
                  end else begin
                     r_next.dataWe = 1'b1;
                     r_next.dataWdata = memVal;
                  end
               end
               // A bus write to the low byte waits for a cycle with no branch.
               if (!flow && r_reg.pclPending) begin
                  r_next.pc = {r_reg.pc[mpfc_pkg::PC_W-1:8], r_reg.pclValue};
                  r_next.pclPending = 1'b0;
                  flow = 1'b1;
               end
               // Discarding the prefetch makes the next cycle a dummy.
               if (flow) begin
                  r_next.fetchValid = 1'b0;
               end
            end
            default: r_next.ph = mpfc_pkg::PH_T1;
         endcase
      end

      // Edge sets pending after any clear above, so a late event is kept.
      if (r_reg.intSync2 && !r_reg.intPrev) begin
         r_next.intPending = 1'b1;
      end

      // APB: answer in the second access cycle, error on unmapped offsets.
      if (psel && penable && !r_reg.pready) begin
         r_next.pready = 1'b1;
         r_next.prdata = 32'h0000_0000;
         case (paddr)
            mpfc_pkg::REG_CTRL: begin
               if (pwrite) begin
                  r_next.run = ctrlWr.run;
                  r_next.intEnable = ctrlWr.intEnable;
               end else begin
                  r_next.prdata = ctrlRd;
               end
            end
            mpfc_pkg::REG_PCL: begin
               if (pwrite) begin
                  r_next.pclPending = 1'b1;
                  r_next.pclValue = pwdata[7:0];
               end else begin
                  r_next.prdata = {24'h00_0000, r_reg.pc[7:0]};
               end
            end
            mpfc_pkg::REG_STATUS: begin
               if (!pwrite) begin
                  r_next.prdata = statRd;
               end
            end
            default: r_next.pslverr = 1'b1;
         endcase
      end
   end

   // ==========================================================
   // State register; reset starts at the reset vector with nothing fetched.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         r_reg <= '0;
         r_reg.pc <= mpfc_pkg::RESET_VECTOR;
         r_reg.ph <= mpfc_pkg::PH_T1;
      end else begin
         r_reg <= r_next;
      end
   end

   // Outputs come straight from the state register.
   assign prdata = r_reg.prdata;
   assign pready = r_reg.pready;
   assign pslverr = r_reg.pslverr;
   assign progAddr = r_reg.progAddr;
   assign dataAddr = r_reg.dataAddr;
   assign dataWe = r_reg.dataWe;
   assign dataWdata = r_reg.dataWdata;
   assign intAck = r_reg.intAck;

endmodule : mpfc_core

// ---- src/mpfc_pkg.sv ----
// Shared constants and types of the program-flow core.
package mpfc_pkg;

   // ==========================================================
   // Sizes.
   localparam int PC_W = 13;
   localparam int STACK_DEPTH = 8;
   localparam int SP_W = 4;
   localparam logic [3:0] DAA_LIMIT = 4'h9;
   localparam logic [3:0] DAA_ADJ = 4'h6;

   // ==========================================================
   // Vectors and the data address that aliases the counter low byte.
   localparam logic [PC_W-1:0] RESET_VECTOR = 13'h0000;
   localparam logic [PC_W-1:0] INT_VECTOR = 13'h0004;
   localparam logic [7:0] PCL_DATA_ADDR = 8'h02;

   // ==========================================================
   // APB register byte offsets.
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_PCL = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;

   // ==========================================================
   // Phases of one instruction cycle, Gray coded.
   typedef enum logic [1:0] {
      PH_T1 = 2'h0,
      PH_T2 = 2'h1,
      PH_T3 = 2'h3,
      PH_T4 = 2'h2
   } mpfc_phase_t;

   typedef enum logic [2:0] {
      CL_ALU = 3'h0,
      CL_LIT = 3'h1,
      CL_JUMP = 3'h2,
      CL_CALL = 3'h3,
      CL_SKIP = 3'h4,
      CL_RET = 3'h5,
      CL_MOVAM = 3'h6,
      CL_NOP = 3'h7
   } mpfc_class_t;

   typedef enum logic [3:0] {
      ALU_ADD = 4'h0, ALU_ADC = 4'h1, ALU_SUB = 4'h2, ALU_SBC = 4'h3,
      ALU_DAA = 4'h4, ALU_AND = 4'h5, ALU_OR = 4'h6, ALU_XOR = 4'h7,
      ALU_CPL = 4'h8, ALU_RR = 4'h9, ALU_RRC = 4'ha, ALU_RL = 4'hb,
      ALU_RLC = 4'hc, ALU_INC = 4'hd, ALU_DEC = 4'he, ALU_MOV = 4'hf
   } mpfc_aluop_t;

   // Skip kinds sit in the low two bits of the operation field.
   typedef enum logic [1:0] {
      SK_SZ = 2'h0,
      SK_SNZ = 2'h1,
      SK_SIZ = 2'h2,
      SK_SDZ = 2'h3
   } mpfc_skip_t;

   // Instruction word layouts.
   typedef struct packed {
      mpfc_class_t cls;
      logic [3:0] op;
      logic destMem;
      logic [7:0] addr;
   } mpfc_opword_t;

   typedef struct packed {
      mpfc_class_t cls;
      logic [PC_W-1:0] target;
   } mpfc_brword_t;

   // APB register layouts.
   typedef struct packed {
      logic [29:0] zero;
      logic intEnable;
      logic run;
   } mpfc_ctrl_t;

   typedef struct packed {
      logic [18:0] zero;
      logic intPending;
      logic ov;
      logic z;
      logic ac;
      logic c;
      logic [7:0] acc;
   } mpfc_status_t;

endpackage : mpfc_pkg

// ---- src/mpfc_stack.sv ----
// Return-address stack, hidden from software.
`timescale 1ns/10ps
module mpfc_stack #(
   parameter int DEPTH = mpfc_pkg::STACK_DEPTH
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic push,
   input wire logic pop,
   input wire logic [mpfc_pkg::PC_W-1:0] pushData,
   output logic [mpfc_pkg::PC_W-1:0] top,
   output logic full
);

   localparam int IDX_W = $clog2(DEPTH);
   localparam logic [mpfc_pkg::SP_W-1:0] DEPTH_SP = mpfc_pkg::SP_W'(DEPTH);

   typedef struct packed {
      logic [mpfc_pkg::SP_W-1:0] ptr;
      logic [DEPTH-1:0][mpfc_pkg::PC_W-1:0] mem;
   } mpfc_stk_t;

   mpfc_stk_t r_reg;
   mpfc_stk_t r_next;
   logic [IDX_W-1:0] topIdx;

   // Full is derived from the depth parameter, not a fixed count.
   assign full = (r_reg.ptr == DEPTH_SP);
   assign topIdx = IDX_W'(r_reg.ptr - 4'h1);
   assign top = (r_reg.ptr == 4'h0) ? r_reg.mem[0] : r_reg.mem[topIdx];

   // ==========================================================
   // A push on a full stack still happens and overwrites the newest entry.
   always_comb begin
      r_next = r_reg;
      if (push) begin
         if (!full) begin
            r_next.mem[r_reg.ptr[IDX_W-1:0]] = pushData;
            r_next.ptr = r_reg.ptr + 4'h1;
         end else begin
            r_next.mem[DEPTH-1] = pushData;
         end
      end else if (pop && r_reg.ptr != 4'h0) begin
         r_next.ptr = r_reg.ptr - 4'h1;
      end
   end

   // Reset points the pointer at the top of the empty stack.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

endmodule : mpfc_stack

// ---- verif/mpfc_core_sva.sv ----
// Port-level assertions of the program-flow core.
`timescale 1ns/10ps
module mpfc_core_sva (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [mpfc_pkg::PC_W-1:0] progAddr,
   input wire logic dataWe,
   input wire logic intAck
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   logic mapped;
   // ==========================================
   // Helpers.
   // Only the three register words decode; the stack has no address.
   assign mapped = paddr inside {mpfc_pkg::REG_CTRL, mpfc_pkg::REG_PCL, mpfc_pkg::REG_STATUS};
   // An access phase that is not yet answered.
   sequence s_taken;
      psel && penable && !pready;
   endsequence
   sequence s_answer;
      ##1 pready ##1 !pready;
   endsequence
   // ==========================================
   // Checks.
   a_apb_answer: assert property (s_taken |-> s_answer)
      else $error("apb answer late or not a pulse");
   a_err_unmapped: assert property ((s_taken and !mapped) |=> pslverr && prdata == '0)
      else $error("unmapped access not refused");
   a_err_mapped: assert property ((s_taken and mapped) |=> !pslverr)
      else $error("mapped access refused");
   a_fetch_hold: assert property (progAddr != $past(progAddr) |=> $stable(progAddr) [*3])
      else $error("fetch address moved within a cycle");
   a_store_spacing: assert property (dataWe |=> !dataWe [*3])
      else $error("two stores in one instruction cycle");
   a_ack_pulse: assert property (intAck |=> !intAck [*3])
      else $error("acknowledge not a single pulse");
   a_ack_vector: assert property (intAck |-> ##[1:8] progAddr == mpfc_pkg::INT_VECTOR)
      else $error("interrupt vector not fetched");
   a_reset_clear: assert property ($fell(reset) |-> progAddr == '0 && !dataWe && !intAck)
      else $error("state not cleared by reset");
endmodule : mpfc_core_sva

bind mpfc_core mpfc_core_sva u_sva (.core_clk(core_clk), .reset(reset), .psel(psel),
   .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .progAddr(progAddr), .dataWe(dataWe), .intAck(intAck));

// ---- verif/mpfc_core_test.sv ----
// Self-checking bench of the program-flow core.
`timescale 1ns/10ps
module mpfc_core_test;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [12:0] progAddr;
   logic [15:0] progData;
   logic [7:0] dataAddr;
   logic dataWe;
   logic [7:0] dataWdata;
   logic [7:0] dataRdata;
   logic intReq = 1'b0;
   logic intAck;
   logic [31:0] rd;
   logic err;
   int bad_count = 0;
   int checked = 0;
   int cycles = 0;
   int acks = 0;

   mpfc_core u_dut (.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .progAddr(progAddr), .progData(progData), .dataAddr(dataAddr),
      .dataWe(dataWe), .dataWdata(dataWdata), .dataRdata(dataRdata), .intReq(intReq),
      .intAck(intAck));
   mpfc_mem u_mem (.core_clk(core_clk), .progAddr(progAddr), .progData(progData),
      .dataAddr(dataAddr), .dataWe(dataWe), .dataWdata(dataWdata), .dataRdata(dataRdata));

   always #5 core_clk = ~core_clk;

   // Hang guard and acknowledge counter.
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (intAck === 1'b1) begin
         acks <= acks + 1;
      end
      if (cycles == 3000) begin
         bad_count++;
         tally_and_finish();
      end
   end

   task tally_and_finish;
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : tally_and_finish

   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // One APB transfer; read data and error are taken at the answering edge.
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      chk("pready", 32'h1, {31'h0, pready});
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Run the stored program, then poke registers and the interrupt pin.
   initial begin
      repeat (10) @(posedge core_clk);
      reset <= 1'b0;
      apb(1'b1, mpfc_pkg::REG_CTRL, 32'h0000_0001);
      repeat (250) @(posedge core_clk);
      chk("mem10", 8'h5A, u_mem.mem[16]);
      chk("mem11", 8'h1A, u_mem.mem[17]);
      chk("mem12", 8'h77, u_mem.mem[18]);
      chk("mem14", 8'h00, u_mem.mem[20]);
      chk("mem15", 8'h77, u_mem.mem[21]);
      apb(1'b1, mpfc_pkg::REG_STATUS, 32'h0000_0000);
      apb(1'b0, mpfc_pkg::REG_STATUS, 32'h0000_0000);
      chk("acc", 8'h77, rd[7:0]);
      // The add of 5A and C0 carries out; nothing since has touched the carry.
      chk("flags", 5'h01, rd[12:8]);
      chk("status err", 1'b0, err);
      apb(1'b0, 8'h0C, 32'h0000_0000);
      chk("unmapped err", 1'b1, err);
      chk("unmapped data", 32'h0000_0000, rd);
      apb(1'b1, mpfc_pkg::REG_PCL, 32'h0000_0050);
      repeat (60) @(posedge core_clk);
      chk("mem16", 8'h77, u_mem.mem[22]);
      chk("mem17", 8'h6F, u_mem.mem[23]);
      // The loop at 84 leaves the counter at one of three words.
      apb(1'b0, mpfc_pkg::REG_PCL, 32'h0000_0000);
      chk("pcl", 32'h1, {31'h0, rd[7:0] inside {8'h54, 8'h55, 8'h56}});
      apb(1'b1, mpfc_pkg::REG_CTRL, 32'h0000_0003);
      intReq <= 1'b1;
      repeat (3) @(posedge core_clk);
      intReq <= 1'b0;
      repeat (80) @(posedge core_clk);
      chk("acks", 32'h1, acks);
      chk("mem30", 8'h70, u_mem.mem[48]);
      apb(1'b0, mpfc_pkg::REG_CTRL, 32'h0000_0000);
      chk("ctrl", 32'h0000_0003, rd);
      tally_and_finish();
   end
endmodule : mpfc_core_test

// ---- verif/mpfc_mem.sv ----
// Program and data memory partner of the program-flow core.
`timescale 1ns/10ps
module mpfc_mem (
   input wire logic core_clk,
   input wire logic [12:0] progAddr,
   output logic [15:0] progData,
   input wire logic [7:0] dataAddr,
   input wire logic dataWe,
   input wire logic [7:0] dataWdata,
   output logic [7:0] dataRdata
);
   logic [15:0] rom [0:127];
   logic [7:0] mem [0:255];
   // Unlisted words are nops, so a stray fetch does no harm.
   initial begin
      for (int i = 0; i < 256; i++) begin
         mem[i] = 8'h00;
      end
      for (int i = 0; i < 128; i++) begin
         rom[i] = 16'hE000;
      end
      rom[0] = 16'h3E5A;
      rom[1] = 16'hC010;
      rom[2] = 16'h20C0;
      rom[3] = 16'h4020;
      rom[4] = 16'hC030;
      rom[5] = 16'hA200;
      rom[32] = 16'hC011;
      rom[33] = 16'h6040;
      rom[34] = 16'hC012;
      rom[35] = 16'h8013;
      rom[36] = 16'hC014;
      rom[37] = 16'hC015;
      rom[38] = 16'h4026;
      rom[64] = 16'h3E77;
      rom[65] = 16'hA000;
      rom[80] = 16'hC016;
      // Literal subtract, store, decrement-and-skip, then a tight loop.
      rom[81] = 16'h2407;
      rom[82] = 16'hC017;
      rom[83] = 16'h8617;
      rom[84] = 16'h4054;
   end
   // Registered reads, as synchronous memories answer.
   always @(posedge core_clk) begin
      progData <= rom[progAddr[6:0]];
      dataRdata <= mem[dataAddr];
      if (dataWe === 1'b1) begin
         mem[dataAddr] <= dataWdata;
      end
   end
endmodule : mpfc_mem
